//--- shared/dsp_cfg_params.svh
// offsets, reset values, write masks and field positions of the config bank
`ifndef DSP_CFG_PARAMS_SVH
`define DSP_CFG_PARAMS_SVH

`define OFS_GAIN 8'hC0
`define OFS_SKIP 8'hC1
`define OFS_CROSS 8'hC2
`define OFS_BOOST_L 8'hC3
`define OFS_BOOST_R 8'hC4
`define OFS_FGAIN 8'hC5
`define OFS_MASK 8'hD0
`define OFS_TYPE 8'hD1
`define OFS_TEST1 8'hF0
`define OFS_TEST2 8'hF1
`define OFS_TEST3 8'hF2
`define OFS_TEST4 8'hF3
`define OFS_TEST5 8'hF4

`define RST_ZERO 8'h00
`define RST_MASK 8'h70
`define RST_TYPE 8'h08
`define RST_TEST5 8'h02

`define WM_GAIN 8'h0F
`define WM_SKIP 8'hFE
`define WM_CROSS 8'h1F
`define WM_FGAIN 8'h03
`define WM_FAULT 8'h7F
`define WM_TEST4 8'h03
`define WM_TEST5 8'h0F

`define FINAL_GAIN_BIT 3
`define LOW_SKIP_BIT 1
`define OC_TYPE_BIT 3
`define HEADROOM_TOP_CODE 3'h3
`define HEADROOM_MAX_STEPS 3'h4
`define BYTE_BITS 4'h8
`define I2C_ADDR_DEFAULT 7'h2A

`endif

//--- shared/dsp_cfg_pkg.sv
// types shared by the gain, skip and fault configuration bank
package dsp_cfg_pkg;

  typedef logic [6:0] fault_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_REG  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100,
    ST_ACK  = 3'b101,
    ST_MACK = 3'b110
  } link_state_e;

  typedef struct packed {
    logic       finalGainBoost;
    logic [2:0] headroomSteps;
    logic       leftMidFirstStageSkip;
    logic       leftMidSecondStageSkip;
    logic       rightMidFirstStageSkip;
    logic       rightMidSecondStageSkip;
    logic       leftHighStageSkip;
    logic       rightHighStageSkip;
    logic       leftLowStageSkip;
    logic       rightLowStageSkip;
    logic       lowCrossHighpassBypass;
    logic       highCrossLowpassBypass;
    logic       highCrossHighpassBypass;
    logic       lowCrossLowpassBypass;
    logic       lowBandAllpassBypass;
    logic [7:0] leftBoostStagesOneToEight;
    logic [7:0] rightBoostStagesOneToEight;
  } cfg_s;

endpackage

//--- src/sync_two_ff.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module sync_two_ff #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_two_ff width must be at least one");
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg <= '1;
      dout     <= '1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

`default_nettype wire

//--- src/dsp_gain_skip_fault_config.sv
// two-wire reachable gain, stage skip and fault policy registers
//
// Behaviour
// RULE1 - final gain bit: 0 unity, 1 plus 6 dB
// RULE2 - pair code sets equal cut/boost, 6 dB steps
// RULE3 - mid/high skip bit: one stage not two
// RULE4 - skip bit 1 drives both low stages
// RULE5 - bits 4,3 bypass crossover filters
// RULE6 - bits 2,1,0 bypass remaining compressor filters
// RULE7 - left and right eight-bit boosts reset zero
// RULE8 - clock fault masks bits 6..4 reset one
// RULE9 - power fault masks bits 3..0 reset zero
// RULE10 - type bit: 0 auto recover, 1 latch
// RULE11 - over-current type resets to latch
// RULE12 - masked source never drives fault nor latches
`timescale 1ns/100ps
`default_nettype none
`include "dsp_cfg_params.svh"

module dsp_gain_skip_fault_config
  import dsp_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `I2C_ADDR_DEFAULT
) (
  input  wire logic   clock,
  input  wire logic   srst,
  input  wire logic   sclIn,
  input  wire logic   sdaIn,
  output logic        sdaOut,
  output logic        sdaOe,
  input  wire fault_t faultRaw,
  input  wire logic   faultClear,
  output logic        faultNOut,
  output logic        faultNOe,
  output fault_t      faultActive,
  output cfg_s        cfgOut
);

  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
    $error("device address falls in a reserved two-wire range");
  end

  logic [1:0]  pinSync;
  logic        sclS;
  logic        sdaS;
  logic        sclD_reg;
  logic        sdaD_reg;
  logic        startCond;
  logic        stopCond;
  logic        sclRise;
  logic        sclFall;

  link_state_e state_reg;
  link_state_e ackNext_reg;
  logic [3:0]  bitCnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  ptr_reg;
  logic        wrPulse_reg;
  logic [7:0]  wrAddr_reg;
  logic [7:0]  wrData_reg;
  logic [7:0]  rdData;

  logic [7:0]  gain_reg;
  logic [7:0]  skip_reg;
  logic [7:0]  cross_reg;
  logic [7:0]  boostL_reg;
  logic [7:0]  boostR_reg;
  logic [7:0]  fGain_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  type_reg;
  logic [7:0]  test1_reg;
  logic [7:0]  test3_reg;
  logic [7:0]  test4_reg;
  logic [7:0]  test5_reg;

  cfg_s        cfg_next;
  fault_t      maskBits;
  fault_t      latch_reg;
  fault_t      latchSet;
  fault_t      latch_next;
  fault_t      act_next;
  logic [2:0]  pairCode;
  logic [5:0]  skipUpper;

  // pins are asynchronous to the core clock
  sync_two_ff #(
    .WIDTH (2)
  ) u_pin_sync (
    .clock (clock),
    .srst  (srst),
    .din   ({sclIn, sdaIn}),
    .dout  (pinSync)
  );

  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  always_ff @(posedge clock) begin
    if (srst) begin
      sclD_reg <= 1'b1;
      sdaD_reg <= 1'b1;
    end else begin
      sclD_reg <= sclS;
      sdaD_reg <= sdaS;
    end
  end

  assign startCond = sclS & sclD_reg & sdaD_reg & ~sdaS;
  assign stopCond  = sclS & sclD_reg & ~sdaD_reg & sdaS;
  assign sclRise   = sclS & ~sclD_reg;
  assign sclFall   = ~sclS & sclD_reg;

  // two-wire slave: address, pointer, then auto-incrementing data bytes
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg   <= ST_IDLE;
      ackNext_reg <= ST_IDLE;
      bitCnt_reg  <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      sdaOe       <= 1'b0;
      wrPulse_reg <= 1'b0;
      wrAddr_reg  <= 8'h00;
      wrData_reg  <= 8'h00;
    end else begin
      wrPulse_reg <= 1'b0;
      if (startCond) begin
        state_reg  <= ST_DEV;
        bitCnt_reg <= 4'h0;
        sdaOe      <= 1'b0;
      end else if (stopCond) begin
        state_reg <= ST_IDLE;
        sdaOe     <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          ST_DEV, ST_REG, ST_WR: begin
            if (sclRise && bitCnt_reg != `BYTE_BITS) begin
              shift_reg  <= {shift_reg[6:0], sdaS};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == `BYTE_BITS) begin
              bitCnt_reg <= 4'h0;
              state_reg  <= ST_ACK;
              sdaOe      <= 1'b1;
              if (state_reg == ST_DEV) begin
                ackNext_reg <= shift_reg[0] ? ST_RD : ST_REG;
                if (shift_reg[7:1] != DEV_ADDR) begin
                  state_reg <= ST_IDLE;
                  sdaOe     <= 1'b0;
                end
              end else if (state_reg == ST_REG) begin
                ptr_reg     <= shift_reg;
                ackNext_reg <= ST_WR;
              end else begin
                wrPulse_reg <= 1'b1;
                wrAddr_reg  <= ptr_reg;
                wrData_reg  <= shift_reg;
                ptr_reg     <= ptr_reg + 8'h01;
                ackNext_reg <= ST_WR;
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              state_reg  <= ackNext_reg;
              bitCnt_reg <= 4'h0;
              if (ackNext_reg == ST_RD) begin
                shift_reg <= rdData;
                ptr_reg   <= ptr_reg + 8'h01;
                sdaOe     <= ~rdData[7];
              end else begin
                sdaOe <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (sclRise) begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_reg == `BYTE_BITS) begin
                sdaOe     <= 1'b0;
                state_reg <= ST_MACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sdaOe     <= ~shift_reg[6];
              end
            end
          end
          ST_MACK: begin
            if (sclRise) begin
              if (sdaS) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg   <= ST_ACK;
                ackNext_reg <= ST_RD;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge clock) begin
    if (srst) begin
      sdaOut    <= 1'b0;
      faultNOut <= 1'b0;
    end else begin
      sdaOut    <= 1'b0;
      faultNOut <= 1'b0;
    end
  end

  // register file; reserved bits are masked off and read zero
  always_ff @(posedge clock) begin
    if (srst) begin
      gain_reg   <= `RST_ZERO; // [RULE1] [RULE2]
      skip_reg   <= `RST_ZERO; // [RULE3] [RULE4]
      cross_reg  <= `RST_ZERO; // [RULE5] [RULE6]
      boostL_reg <= `RST_ZERO; // [RULE7]
      boostR_reg <= `RST_ZERO; // [RULE7]
      fGain_reg  <= `RST_ZERO;
      mask_reg   <= `RST_MASK; // [RULE8] [RULE9]
      type_reg   <= `RST_TYPE; // [RULE10] [RULE11]
      test1_reg  <= `RST_ZERO;
      test3_reg  <= `RST_ZERO;
      test4_reg  <= `RST_ZERO;
      test5_reg  <= `RST_TEST5;
    end else if (wrPulse_reg) begin
      case (wrAddr_reg)
        `OFS_GAIN:    gain_reg   <= wrData_reg & `WM_GAIN;
        `OFS_SKIP:    skip_reg   <= wrData_reg & `WM_SKIP;
        `OFS_CROSS:   cross_reg  <= wrData_reg & `WM_CROSS;
        `OFS_BOOST_L: boostL_reg <= wrData_reg;
        `OFS_BOOST_R: boostR_reg <= wrData_reg;
        `OFS_FGAIN:   fGain_reg  <= wrData_reg & `WM_FGAIN;
        `OFS_MASK:    mask_reg   <= wrData_reg & `WM_FAULT;
        `OFS_TYPE:    type_reg   <= wrData_reg & `WM_FAULT;
        `OFS_TEST1:   test1_reg  <= wrData_reg;
        `OFS_TEST3:   test3_reg  <= wrData_reg;
        `OFS_TEST4:   test4_reg  <= wrData_reg & `WM_TEST4;
        `OFS_TEST5:   test5_reg  <= wrData_reg & `WM_TEST5;
        default:      test1_reg  <= test1_reg;
      endcase
    end
  end

  always_comb begin
    case (ptr_reg)
      `OFS_GAIN:    rdData = gain_reg;
      `OFS_SKIP:    rdData = skip_reg;
      `OFS_CROSS:   rdData = cross_reg;
      `OFS_BOOST_L: rdData = boostL_reg;
      `OFS_BOOST_R: rdData = boostR_reg;
      `OFS_FGAIN:   rdData = fGain_reg;
      `OFS_MASK:    rdData = mask_reg;
      `OFS_TYPE:    rdData = type_reg;
      `OFS_TEST1:   rdData = test1_reg;
      `OFS_TEST3:   rdData = test3_reg;
      `OFS_TEST4:   rdData = test4_reg;
      `OFS_TEST5:   rdData = test5_reg;
      default:      rdData = 8'h00;
    endcase
  end

  // each step is 6 dB of input cut and equal output boost
  function automatic logic [2:0] headroom_steps(input logic [2:0] code);
    headroom_steps = (code > `HEADROOM_TOP_CODE) ? `HEADROOM_MAX_STEPS : code;
  endfunction

  assign pairCode  = gain_reg[2:0];
  assign skipUpper = skip_reg[7:2];

  always_comb begin
    cfg_next = '0;
    cfg_next.finalGainBoost = gain_reg[`FINAL_GAIN_BIT]; // [RULE1]
    cfg_next.headroomSteps = headroom_steps(pairCode); // [RULE2]
    cfg_next.leftMidFirstStageSkip = skip_reg[7]; // [RULE3]
    cfg_next.leftMidSecondStageSkip = skip_reg[6]; // [RULE3]
    cfg_next.rightMidFirstStageSkip = skip_reg[5]; // [RULE3]
    cfg_next.rightMidSecondStageSkip = skip_reg[4]; // [RULE3]
    cfg_next.leftHighStageSkip = skip_reg[3]; // [RULE3]
    cfg_next.rightHighStageSkip = skip_reg[2]; // [RULE3]
    cfg_next.leftLowStageSkip = skip_reg[`LOW_SKIP_BIT]; // [RULE4]
    cfg_next.rightLowStageSkip = skip_reg[`LOW_SKIP_BIT]; // [RULE4]
    cfg_next.lowCrossHighpassBypass = cross_reg[4]; // [RULE5]
    cfg_next.highCrossLowpassBypass = cross_reg[3]; // [RULE5]
    cfg_next.highCrossHighpassBypass = cross_reg[2]; // [RULE6]
    cfg_next.lowCrossLowpassBypass = cross_reg[1]; // [RULE6]
    cfg_next.lowBandAllpassBypass = cross_reg[0]; // [RULE6]
    cfg_next.leftBoostStagesOneToEight = boostL_reg; // [RULE7]
    cfg_next.rightBoostStagesOneToEight = boostR_reg; // [RULE7]
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfgOut <= '0;
    end else begin
      cfgOut <= cfg_next;
    end
  end

  // fault policy: new latch events win over a same-cycle clear
  assign maskBits   = mask_reg[6:0];
  assign latchSet   = faultRaw & ~maskBits & type_reg[6:0]; // [RULE10] [RULE12]
  assign latch_next = ((latch_reg & ~{7{faultClear}}) | latchSet) & ~maskBits;
  assign act_next   = (faultRaw | latch_next) & ~maskBits; // [RULE12]

  always_ff @(posedge clock) begin
    if (srst) begin
      latch_reg   <= '0;
      faultActive <= '0;
      faultNOe    <= 1'b0;
    end else begin
      latch_reg   <= latch_next; // [RULE10]
      faultActive <= act_next;
      faultNOe    <= |act_next; // [RULE12]
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_gain_written;
    wrPulse_reg && (wrAddr_reg == `OFS_GAIN);
  endsequence

  sequence s_latch_cause;
    latchSet != 7'h00;
  endsequence

  a_final_gain: assert property ( // [RULE1]
    s_gain_written |-> ##2 (cfgOut.finalGainBoost == $past(wrData_reg[3], 2)))
    else $error("final gain does not follow written bit");

  a_headroom_map: assert property ( // [RULE2]
    ##1 (cfgOut.headroomSteps == (($past(pairCode) > 3'h3) ? 3'h4 : $past(pairCode))))
    else $error("headroom steps do not match pair code");

  a_mid_high_skip: assert property ( // [RULE3]
    ##1 ({cfgOut.leftMidFirstStageSkip, cfgOut.leftMidSecondStageSkip,
          cfgOut.rightMidFirstStageSkip, cfgOut.rightMidSecondStageSkip,
          cfgOut.leftHighStageSkip, cfgOut.rightHighStageSkip} == $past(skipUpper)))
    else $error("mid or high stage skip mismatch");

  a_low_skip_pair: assert property ( // [RULE4]
    ##1 (cfgOut.leftLowStageSkip == $past(skip_reg[1]) &&
         cfgOut.rightLowStageSkip == cfgOut.leftLowStageSkip))
    else $error("low stage skips not driven by one bit");

  a_cross_bypass: assert property ( // [RULE5]
    ##1 ({cfgOut.lowCrossHighpassBypass, cfgOut.highCrossLowpassBypass} ==
         $past(cross_reg[4:3])))
    else $error("crossover bypass mismatch");

  a_band_bypass: assert property ( // [RULE6]
    $past(srst) |-> (cross_reg == 8'h00) ##1
    ({cfgOut.highCrossHighpassBypass, cfgOut.lowCrossLowpassBypass,
      cfgOut.lowBandAllpassBypass} == $past(cross_reg[2:0])))
    else $error("band filter bypass mismatch");

  a_boost_follow: assert property ( // [RULE7]
    $past(srst) |-> (boostL_reg == 8'h00 && boostR_reg == 8'h00) ##2
    (cfgOut.leftBoostStagesOneToEight == $past(boostL_reg) &&
     cfgOut.rightBoostStagesOneToEight == $past(boostR_reg)))
    else $error("boost controls mismatch");

  a_clock_mask_reset: assert property ( // [RULE8]
    $past(srst) |-> (mask_reg[6:4] == 3'b111))
    else $error("clock fault masks not set after reset");

  a_power_mask_reset: assert property ( // [RULE9]
    $past(srst) |-> (mask_reg[3:0] == 4'h0 && mask_reg[7] == 1'b0))
    else $error("power fault masks not clear after reset");

  a_latch_holds: assert property ( // [RULE10]
    s_latch_cause |=> ((latch_reg & $past(latchSet)) == $past(latchSet)))
    else $error("latch type fault not latched");

  a_auto_no_latch: assert property ( // [RULE10]
    (latchSet == 7'h00 && latch_reg == 7'h00) |=> (latch_reg == 7'h00))
    else $error("auto recovery fault latched");

  a_oc_latch_reset: assert property ( // [RULE11]
    $past(srst) |-> (type_reg == 8'h08))
    else $error("over-current type not latch after reset");

  a_masked_silent: assert property ( // [RULE12]
    ((faultRaw & ~maskBits) == 7'h00 && latch_reg == 7'h00) |=> !faultNOe)
    else $error("masked source drove fault pin");

  a_fault_pin: assert property ( // [RULE12]
    (act_next != 7'h00) |=> (faultNOe && faultActive == $past(act_next)))
    else $error("unmasked fault not driven");

endmodule

`default_nettype wire

//--- verif/i2c_host_model.sv
// two-wire host controller model driving the config bank pins
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model #(
  parameter int HALF = 10
) (
  input  wire logic clock,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic holdHalf();
    repeat (HALF) @(posedge clock);
  endtask

  // data moves two clocks after the scl fall so the pin sync never sees both change together
  task automatic bitIo(input logic txBit, output logic rxBit);
    repeat (2) @(posedge clock);
    sdaLow <= !txBit;
    holdHalf();
    sclOut <= 1'b1;
    holdHalf();
    rxBit = sdaLine;
    sclOut <= 1'b0;
  endtask

  task automatic startCond();
    repeat (2) @(posedge clock);
    sdaLow <= 1'b0;
    holdHalf();
    sclOut <= 1'b1;
    holdHalf();
    sdaLow <= 1'b1;
    holdHalf();
    sclOut <= 1'b0;
  endtask

  task automatic stopCond();
    repeat (2) @(posedge clock);
    sdaLow <= 1'b1;
    holdHalf();
    sclOut <= 1'b1;
    holdHalf();
    sdaLow <= 1'b0;
    holdHalf();
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], r);
    end
    bitIo(1'b1, r);
    ack = !r;
  endtask

  task automatic getByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, d[i]);
    end
    bitIo(last, r);
  endtask

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2;
    startCond();
    sendByte({dev, 1'b0}, a0);
    sendByte(ofs, a1);
    sendByte(d, a2);
    stopCond();
    ok = a0 & a1 & a2;
  endtask

  task automatic readReg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d,
                         output logic ok);
    logic a0, a1, a2;
    startCond();
    sendByte({dev, 1'b0}, a0);
    sendByte(ofs, a1);
    startCond();
    sendByte({dev, 1'b1}, a2);
    getByte(1'b1, d);
    stopCond();
    ok = a0 & a1 & a2;
  endtask
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the gain, skip and fault config bank
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import dsp_cfg_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A;
  localparam int         CW  = $bits(cfg_s);

  typedef struct packed {
    logic       doWrite;
    logic [7:0] ofs;
    logic [7:0] wr;
    logic [7:0] rd;
  } row_s;

  logic       clock      = 1'b0;
  logic       srst       = 1'b1;
  fault_t     faultRaw   = 7'h00;
  logic       faultClear = 1'b0;
  logic       sclIn;
  logic       hostSdaLow;
  logic       sdaOut;
  logic       sdaOe;
  logic       faultNOut;
  logic       faultNOe;
  wire logic  sdaLine;
  fault_t     faultActive;
  cfg_s       cfgOut;
  cfg_s       expCfg;
  logic [7:0] rd;
  logic       ok;
  int         error_cnt       = 0;
  int         samples_checked = 0;

  row_s rows [17] = '{
    '{1'h0, 8'hC0, 8'h00, 8'h00}, '{1'h0, 8'hC1, 8'h00, 8'h00}, '{1'h0, 8'hC2, 8'h00, 8'h00},
    '{1'h0, 8'hC3, 8'h00, 8'h00}, '{1'h0, 8'hC4, 8'h00, 8'h00}, '{1'h0, 8'hD0, 8'h00, 8'h70},
    '{1'h0, 8'hD1, 8'h00, 8'h08}, '{1'h1, 8'hC0, 8'hFF, 8'h0F}, '{1'h1, 8'hC1, 8'hFF, 8'hFE},
    '{1'h1, 8'hC2, 8'hFF, 8'h1F}, '{1'h1, 8'hC3, 8'hA5, 8'hA5}, '{1'h1, 8'hC4, 8'h5A, 8'h5A},
    '{1'h1, 8'hD1, 8'hFF, 8'h7F}, '{1'h1, 8'hD0, 8'hFF, 8'h7F}, '{1'h1, 8'hF1, 8'hFF, 8'h00},
    '{1'h1, 8'hB0, 8'hFF, 8'h00}, '{1'h1, 8'hC5, 8'hFF, 8'h03}
  };

  // open-drain data line with pull-up
  assign sdaLine = !((sdaOe && !sdaOut) || hostSdaLow);

  always #2.5 clock = !clock;

  dsp_gain_skip_fault_config #(.DEV_ADDR(DEV)) dsp_gain_skip_fault_config_inst (
    .clock(clock), .srst(srst), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .faultRaw(faultRaw), .faultClear(faultClear), .faultNOut(faultNOut),
    .faultNOe(faultNOe), .faultActive(faultActive), .cfgOut(cfgOut)
  );

  i2c_host_model i2c_host_model_inst (
    .clock(clock), .sdaLine(sdaLine), .sclOut(sclIn), .sdaLow(hostSdaLow)
  );

  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic writeAcked(input logic [7:0] ofs, input logic [7:0] d);
    i2c_host_model_inst.writeReg(DEV, ofs, d, ok);
    check(CW'(ok), CW'(1'b1), "write acked");
  endtask

  task automatic readExpect(input logic [7:0] ofs, input logic [7:0] exp);
    i2c_host_model_inst.readReg(DEV, ofs, rd, ok);
    check(CW'({ok, rd}), CW'({1'b1, exp}), "read back");
  endtask

  // raw faults land at one edge, pin and sources are looked at one edge later
  task automatic faultStep(input fault_t raw, input logic clr, input logic [7:0] exp);
    @(posedge clock);
    faultRaw   <= raw;
    faultClear <= clr;
    @(posedge clock);
    #1;
    check(CW'({faultNOe, faultActive}), CW'(exp), "fault pin and sources");
  endtask

  initial begin
    repeat (80000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    faultStep(7'h48, 1'b0, 8'h88);
    faultStep(7'h00, 1'b0, 8'h88);
    faultStep(7'h00, 1'b1, 8'h00);
    faultStep(7'h01, 1'b0, 8'h81);
    faultStep(7'h00, 1'b0, 8'h00);
    faultStep(7'h08, 1'b1, 8'h88);
    faultStep(7'h00, 1'b0, 8'h88);
    faultStep(7'h00, 1'b1, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].doWrite) begin
        writeAcked(rows[i].ofs, rows[i].wr);
      end
      readExpect(rows[i].ofs, rows[i].rd);
    end
    expCfg = '{finalGainBoost: 1'h1, headroomSteps: 3'h4, leftBoostStagesOneToEight: 8'hA5,
               rightBoostStagesOneToEight: 8'h5A, default: 1'h1};
    check(cfgOut, expCfg, "decoded config");
    for (int c = 0; c < 8; c++) begin
      writeAcked(8'hC0, {4'h0, 1'(c % 2), 3'(c)});
      check(CW'({cfgOut.finalGainBoost, cfgOut.headroomSteps}),
            CW'({1'(c % 2), 3'((c > 3) ? 4 : c)}), "gain fields");
    end
    i2c_host_model_inst.writeReg(7'h2B, 8'hC3, 8'h11, ok);
    check(CW'(ok), CW'(1'b0), "foreign address refused");
    readExpect(8'hC3, 8'hA5);
    faultStep(7'h7F, 1'b0, 8'h00);
    faultStep(7'h00, 1'b0, 8'h00);
    writeAcked(8'hD0, 8'h40);
    writeAcked(8'hD1, 8'h08);
    faultStep(7'h44, 1'b0, 8'h84);
    faultStep(7'h00, 1'b0, 8'h00);
    writeAcked(8'hD0, 8'h00);
    faultStep(7'h44, 1'b0, 8'hC4);
    @(posedge clock);
    srst <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check(CW'(cfgOut), CW'(0), "config cleared by reset");
    check(CW'({faultNOe, faultActive}), CW'(0), "faults cleared by reset");
    @(posedge clock);
    srst <= 1'b0;
    faultRaw <= 7'h00;
    repeat (4) @(posedge clock);
    readExpect(8'hD0, 8'h70);
    readExpect(8'hD1, 8'h08);
    check(CW'({sdaOut, faultNOut}), CW'(0), "open-drain drive values");
    end_of_test();
  end
endmodule

`default_nettype wire
